// >>> otpm_pkg.sv
// package: constants for the one-time program memory block
package otpm_pkg;
    localparam int          OTPM_DEPTH       = 2048;
    localparam int          OTPM_AW          = 11;
    localparam int          OTPM_RAM_DEPTH   = 128;
    localparam int          OTPM_RAM_AW      = 7;
    localparam logic [15:0] OTPM_CPU_BASE    = 16'hf800;
    localparam logic [16:0] OTPM_PROM_BASE   = 17'h00000;
    localparam logic [16:0] OTPM_PROM_LAST   = 17'h007ff;
    localparam logic [16:0] OTPM_SEC_ADDR    = 17'h01101;
    localparam int          OTPM_SEC_BIT     = 0;
    localparam logic [7:0]  OTPM_BLANK       = 8'hff;
    localparam int          OTPM_CLK_MHZ     = 25;
    localparam int          OTPM_PULSE_NS    = 100000;
    localparam int          OTPM_PULSE_CYC   =
        (OTPM_PULSE_NS * OTPM_CLK_MHZ + 999) / 1000;
    localparam int          OTPM_CNT_W       = 13;
    typedef enum logic [2:0] {
        OTPM_IDLE  = 3'b001,
        OTPM_PULSE = 3'b010,
        OTPM_DONE  = 3'b100
    } otpm_state_t;
endpackage

// >>> otpm_core.sv
// one-time program memory with processor port and programming-mode port
// Behaviour
// - 2K memory at f800-ffff for processor, 0000-07ff for programming
// - separate 128-byte static data memory
// - low address bits and data share the same eight port pins
// - settled address/data plus 0.1 ms low write pulse stores the byte
// - after protection bit cleared, programming-mode reads return ff
// - protection bit is bit 0 of 1101; written as fe
`timescale 1ns/1ns
module otpm_core
    import otpm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        test_pin,
    input  wire logic        reset_pin_n,
    input  wire logic        prom_mode_control_pin,
    input  wire logic [15:0] cpu_addr,
    output logic [7:0]       cpu_rdata,
    input  wire logic        ram_we,
    input  wire logic [6:0]  ram_addr,
    input  wire logic [7:0]  ram_wdata,
    output logic [7:0]       ram_rdata,
    input  wire logic [7:0]  shared_addr_data_port_in,
    output logic [7:0]       shared_addr_data_port_out,
    output logic             shared_addr_data_port_oe,
    input  wire logic [8:0]  addr_high,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        write_pulse_pin_n,
    output logic             prom_mode,
    output logic             read_protected
);
    import otpm_pkg::*;

    // a blank part reads all ones; programming can only clear bits
    logic [7:0]  rom [0:OTPM_DEPTH-1] = '{default: OTPM_BLANK};
    logic [7:0]  ram [0:OTPM_RAM_DEPTH-1];

    // two-stage synchronisers for every pin input
    logic [22:0] s1;
    logic [22:0] s2;
    always_ff @(posedge mclk)
    begin
        s1 <= {test_pin, reset_pin_n, prom_mode_control_pin, addr_high,
               shared_addr_data_port_in, ce_n, oe_n, write_pulse_pin_n};
        s2 <= s1;
    end

    logic        p_test;
    logic        p_rst_n;
    logic        p_ctl;
    logic [8:0]  p_ahi;
    logic [7:0]  p_ad;
    logic        p_ce_n;
    logic        p_oe_n;
    logic        p_pgm_n;
    assign {p_test, p_rst_n, p_ctl, p_ahi, p_ad, p_ce_n, p_oe_n, p_pgm_n} = s2;

    // mode decode; programming mode needs the test pin high
    logic mode_now;
    assign mode_now = !p_rst_n && p_ctl && p_test;

    // the low byte follows the pins while chip enable is high or output enable is low; data then shares it
    logic [7:0]  alo;
    logic [7:0]  next_alo;
    logic [16:0] paddr;
    assign paddr = {p_ahi, alo};
    logic in_array;
    assign in_array = paddr <= OTPM_PROM_LAST;
    logic is_sec;
    assign is_sec = paddr == OTPM_SEC_ADDR;

    // write pulse state machine
    otpm_state_t              state;
    otpm_state_t              next_state;
    logic [OTPM_CNT_W-1:0]    cnt;
    logic [OTPM_CNT_W-1:0]    next_cnt;
    logic                     do_write;
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        do_write   = 1'b0;
        next_alo   = alo;
        if (p_ce_n || p_oe_n == 1'b0)
            next_alo = p_ad;
        case (state)
            OTPM_IDLE:
            begin
                next_cnt = '0;
                // the idle cycle that sees the strobe low is the first one
                if (mode_now && !p_pgm_n && !p_ce_n && p_oe_n)
                begin
                    next_state = OTPM_PULSE;
                    next_cnt   = OTPM_CNT_W'(1);
                end
            end
            OTPM_PULSE:
            begin
                // pulse shorter than 0.1 ms stores nothing
                if (p_pgm_n || !mode_now)
                    next_state = OTPM_IDLE;
                else if (cnt == OTPM_CNT_W'(OTPM_PULSE_CYC - 1))
                begin
                    do_write   = 1'b1;
                    next_state = OTPM_DONE;
                end
                else
                    next_cnt = cnt + 1'b1;
            end
            OTPM_DONE:
                if (p_pgm_n)
                    next_state = OTPM_IDLE;
            default:
                next_state = OTPM_IDLE;
        endcase
    end

    // otp cells only lose ones; only rst sets the protection bit sec_cell back to one
    logic sec_cell;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state    <= OTPM_IDLE;
            cnt      <= '0;
            alo      <= 8'h00;
            sec_cell <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
            alo   <= next_alo;
            if (do_write && is_sec)
                sec_cell <= sec_cell & p_ad[OTPM_SEC_BIT];
        end
        if (do_write && in_array)
            rom[paddr[OTPM_AW-1:0]] <= rom[paddr[OTPM_AW-1:0]] & p_ad;
    end

    // length of the current low strobe run, kept for the pulse check
    logic [OTPM_CNT_W-1:0]    low_run;
    logic [OTPM_CNT_W-1:0]    next_low_run;
    always_comb
    begin
        next_low_run = '0;
        if (mode_now && !p_pgm_n && low_run != '1)
            next_low_run = low_run + 1'b1;
        else if (mode_now && !p_pgm_n)
            next_low_run = low_run; // saturates on very long strobes
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            low_run <= '0;
        else
            low_run <= next_low_run;
    end

    // outputs registered; processor window at f800-ffff
    logic [7:0] next_pout;
    logic       next_poe;
    always_comb
    begin
        next_poe  = mode_now && !p_ce_n && !p_oe_n && p_pgm_n;
        if (!sec_cell)
            next_pout = OTPM_BLANK;
        else if (is_sec)
            next_pout = {7'h7f, sec_cell};
        else if (in_array)
            next_pout = rom[paddr[OTPM_AW-1:0]];
        else
            next_pout = OTPM_BLANK;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            shared_addr_data_port_out <= 8'h00;
            shared_addr_data_port_oe  <= 1'b0;
            prom_mode                 <= 1'b0;
            read_protected            <= 1'b0;
            cpu_rdata                 <= 8'h00;
            ram_rdata                 <= 8'h00;
        end
        else
        begin
            shared_addr_data_port_out <= next_pout;
            shared_addr_data_port_oe  <= next_poe;
            prom_mode                 <= mode_now;
            read_protected            <= !sec_cell;
            if (cpu_addr >= OTPM_CPU_BASE)
                cpu_rdata <= rom[cpu_addr[OTPM_AW-1:0]];
            else
                cpu_rdata <= OTPM_BLANK;
            ram_rdata <= ram[ram_addr];
        end
    end

    // data memory write port
    always_ff @(posedge mclk)
    begin
        if (ram_we)
            ram[ram_addr] <= ram_wdata;
    end

    // checks
    prot_read_a: assert property (@(posedge mclk) disable iff (rst)
        !sec_cell |=> shared_addr_data_port_out == OTPM_BLANK)
        else $error("protected read not blank");
    drive_gate_a: assert property (@(posedge mclk) disable iff (rst)
        shared_addr_data_port_oe |-> $past(p_oe_n) == 1'b0
            && $past(p_ce_n) == 1'b0 && $past(p_pgm_n) == 1'b1)
        else $error("data driven without enables");
    pulse_len_a: assert property (@(posedge mclk) disable iff (rst)
        do_write |-> !p_pgm_n
            && low_run == OTPM_CNT_W'(OTPM_PULSE_CYC - 1))
        else $error("write before full pulse");
    mode_pin_a: assert property (@(posedge mclk) disable iff (rst)
        !p_test |=> !prom_mode)
        else $error("programming mode without test pin");
    sec_stick_a: assert property (@(posedge mclk) disable iff (rst)
        !sec_cell |=> !sec_cell)
        else $error("protection bit returned to one");
    cpu_map_a: assert property (@(posedge mclk) disable iff (rst)
        cpu_addr < OTPM_CPU_BASE |=> cpu_rdata == OTPM_BLANK)
        else $error("processor read outside window");
endmodule // otpm_core

// >>> otpm_programmer.sv
// programmer model driving the programming-mode pins
`timescale 1ns/1ns
module otpm_programmer
(
    input  wire logic        mclk,
    input  wire logic [7:0]  dev_out,
    input  wire logic        dev_oe,
    output logic [7:0]       pins,
    output logic [8:0]       addr_high,
    output logic             ce_n,
    output logic             oe_n,
    output logic             write_pulse_pin_n
);
    // idle: chip off, strobe high, no signature voltage ever used
    initial
    begin
        {addr_high, pins} = 17'h00000;
        {ce_n, oe_n, write_pulse_pin_n} = 3'b111;
    end

    // address first, held while chip enable is high
    task automatic setup(input logic [16:0] a);
        @(negedge mclk);
        {addr_high, pins} = a; // only 0000-07ff or 1101 used
        repeat (3) @(negedge mclk);
    endtask

    // settle address and data, then one low strobe pulse
    task automatic write_byte(input logic [16:0] a, input logic [7:0] d,
                              input int cyc);
        setup(a);
        ce_n = 1'b0;
        pins = d;
        repeat (3) @(negedge mclk);
        write_pulse_pin_n = 1'b0;
        repeat (cyc) @(negedge mclk);
        write_pulse_pin_n = 1'b1;
        repeat (4) @(negedge mclk);
        ce_n = 1'b1;
    endtask

    // read back; address pins stay driven, answer after 4 cycles
    task automatic read_byte(input logic [16:0] a, output logic [7:0] d,
                             output logic oe);
        setup(a);
        ce_n = 1'b0;
        oe_n = 1'b0;
        repeat (4) @(negedge mclk);
        d = dev_out;
        oe = dev_oe;
        oe_n = 1'b1;
        ce_n = 1'b1;
    endtask
endmodule // otpm_programmer

// >>> otpm_core_tb_top.sv
// self-checking bench for the one-time program memory block
`timescale 1ns/1ns
module otpm_core_tb_top;
    import otpm_pkg::*;
    typedef struct {
        logic [16:0] a;
        logic [7:0]  d;
        int          cyc;
        logic [7:0]  exp;
    } otpm_row_t;
    logic        mclk, rst, test_pin, reset_pin_n, ctl, ram_we, oe, pm, rp;
    logic [15:0] cpu_addr;
    logic [6:0]  ram_addr;
    logic [7:0]  cpu_rdata, ram_wdata, ram_rdata, pins, dout, rd;
    logic [8:0]  ah;
    logic        ce_n, oe_n, pgm_n;
    logic        rd_oe;
    int          error_cnt = 0;
    int          checks = 0;
    // short pulse refused; second write only clears bits
    otpm_row_t   rows [4] = '{'{17'h00005, 8'ha5, 2500, 8'ha5},
        '{17'h007ff, 8'h3c, 2500, 8'h3c}, '{17'h00006, 8'h00, 100, 8'hff},
        '{17'h00005, 8'h0f, 2500, 8'h05}};

    otpm_core dut (.mclk(mclk), .rst(rst), .test_pin(test_pin),
        .reset_pin_n(reset_pin_n), .prom_mode_control_pin(ctl),
        .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .shared_addr_data_port_in(pins), .shared_addr_data_port_out(dout),
        .shared_addr_data_port_oe(oe), .addr_high(ah), .ce_n(ce_n),
        .oe_n(oe_n), .write_pulse_pin_n(pgm_n), .prom_mode(pm),
        .read_protected(rp));
    otpm_programmer prog (.mclk(mclk), .dev_out(dout), .dev_oe(oe),
        .pins(pins), .addr_high(ah), .ce_n(ce_n), .oe_n(oe_n),
        .write_pulse_pin_n(pgm_n));

    // clock on the oscillator input, 40 ns period
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // mode pins held for the whole programming session
    task automatic set_mode(input logic prom);
        @(negedge mclk);
        {test_pin, reset_pin_n, ctl} = {prom, ~prom, prom};
        repeat (4) @(negedge mclk);
        cmp1(pm, prom);
    endtask
    task automatic cpu_rd(input logic [15:0] a, input logic [7:0] exp);
        cpu_addr = a;
        repeat (2) @(negedge mclk);
        cmp8(cpu_rdata, exp);
    endtask

    // watchdog, well beyond the ~10250 cycles the tests need
    initial
    begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        close_out();
    end

    initial
    begin
        {rst, test_pin, reset_pin_n, ctl, ram_we} = 5'b10100;
        {cpu_addr, ram_addr, ram_wdata} = 31'h0;
        repeat (10) @(negedge mclk);
        cmp1(pm, 1'b0);
        cmp1(rp, 1'b0);
        rst = 1'b0;
        $display("reset test done");
        set_mode(1'b1);
        foreach (rows[i])
        begin
            prog.write_byte(rows[i].a, rows[i].d, rows[i].cyc);
            prog.read_byte(rows[i].a, rd, rd_oe);
            cmp8(rd, rows[i].exp);
            cmp1(rd_oe, 1'b1);
            repeat (4) @(negedge mclk);
            cmp1(oe, 1'b0);
        end
        $display("programming rows done");
        set_mode(1'b0);
        cpu_rd(16'hf805, 8'h05);
        cpu_rd(16'hffff, 8'h3c);
        cpu_rd(16'hf7ff, OTPM_BLANK);
        ram_we = 1'b1; // separate data memory
        {ram_addr, ram_wdata} = {7'h7f, 8'h5a};
        @(negedge mclk);
        ram_we = 1'b0;
        repeat (2) @(negedge mclk);
        cmp8(ram_rdata, 8'h5a);
        $display("processor view done");
        set_mode(1'b1);
        prog.write_byte(OTPM_SEC_ADDR, 8'hfe, 2500); // written once
        repeat (4) @(negedge mclk);
        cmp1(rp, 1'b1);
        prog.read_byte(17'h00005, rd, rd_oe);
        cmp8(rd, OTPM_BLANK);
        cmp1(rd_oe, 1'b1);
        cmp1(pm, 1'b1);
        $display("protection test done");
        close_out();
    end
endmodule // otpm_core_tb_top
